// *** gate_status_cfg.svh ***
// Constants for the gate driver status register bank.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef GATE_STATUS_CFG_SVH
`define GATE_STATUS_CFG_SVH

// Bus shape
`define STAT_W 16
`define ADDR_W 8

// Register offsets
`define SUPPLY_STATUS_OFS 8'h02
`define FUNC_STATUS_OFS 8'h03

// Reset values
`define STATUS_RESET 16'h0000
`define ADC_RESET 7'h00
`define GAIN_RESET 3'h0

// Supply health status fields
`define LOW_PUMP_UV_BIT 0
`define HIGH_PUMP_UV_BIT 1
`define LOGIC_UV_BIT 2
`define LOGIC_OV_BIT 3
`define BUCK_UV_BIT 4
`define BUCK_OV_BIT 5
`define MOTOR_READ_LSB 6
`define MOTOR_READ_MSB 12

// Functional signal status fields
`define HALL_LSB 0
`define HALL_MSB 2
`define HALL_EQ_BIT 3
`define SETPOINT_BIT 4
`define GAIN_LSB 5
`define GAIN_MSB 7

// Field widths
`define ADC_W 7
`define HALL_W 3
`define GAIN_W 3
`define CMP_W 6

// Comparator vector positions on the synchroniser
`define CMP_LOW_PUMP 0
`define CMP_HIGH_PUMP 1
`define CMP_LOGIC_UV 2
`define CMP_LOGIC_OV 3
`define CMP_BUCK_UV 4
`define CMP_BUCK_OV 5

// Strap settle time after reset release
`define CLK_MHZ 200
`define STRAP_SETTLE_NS 20
`define STRAP_SETTLE_CYC ((`STRAP_SETTLE_NS * `CLK_MHZ + 999) / 1000)
`define STRAP_CNT_W 4

`endif

// *** gate_status_pkg.sv ***
// Types for the gate driver status register bank.
// Assumes gate_status_cfg.svh is on the include path.
`include "gate_status_cfg.svh"

package gate_status_pkg;

    typedef logic [`STAT_W-1:0] status_word_t;
    typedef logic [`ADDR_W-1:0] reg_addr_t;
    typedef logic [`ADC_W-1:0] adc_value_t;
    typedef logic [`GAIN_W-1:0] gain_code_t;
    typedef logic [`HALL_W-1:0] hall_levels_t;

    typedef enum logic {
        strap_wait,
        strap_held
    } strap_state_t;

endpackage

// *** sync_vec.sv ***
// Two flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level from outside the clock domain.
`timescale 1ns/1ps
`include "gate_status_cfg.svh"

module sync_vec #(
    parameter int WIDTH = 1
) (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] stable_q;

    // First stage feeds only the second stage
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_q <= '0;
            stable_q <= '0;
        end else begin
            meta_q <= async_in;
            stable_q <= meta_q;
        end
    end

    assign sync_out = stable_q;

endmodule // sync_vec

// *** strap_latch.sv ***
// Captures a synchronised strap level once after reset release.
// Assumes strap_in is already synchronised to mclk_in.
`timescale 1ns/1ps
`include "gate_status_cfg.svh"

module strap_latch
    import gate_status_pkg::*;
(
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic strap_in,
    output logic strap_out
);

    localparam logic [`STRAP_CNT_W-1:0] SETTLE_LAST =
        `STRAP_CNT_W'(`STRAP_SETTLE_CYC);

    strap_state_t state_q;
    logic [`STRAP_CNT_W-1:0] count_q;
    logic strap_q;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= strap_wait;
            count_q <= '0;
            strap_q <= 1'b0;
        end else begin
            case (state_q)
                strap_wait: begin
                    if (count_q == SETTLE_LAST) begin
                        // Value fixed per product variant
                        strap_q <= strap_in;
                        state_q <= strap_held;
                    end else begin
                        count_q <= count_q + 1'b1;
                    end
                end
                strap_held: begin
                    state_q <= strap_held;
                end
                default: begin
                    state_q <= strap_wait;
                end
            endcase
        end
    end

    assign strap_out = strap_q;

endmodule // strap_latch

// *** gate_driver_status_regs.sv ***
// Read-only supply health and functional signal status registers.
// Assumes comparators, hall pins and strap are asynchronous levels;
// converter result and gain code come from logic on mclk_in.
`timescale 1ns/1ps
`include "gate_status_cfg.svh"

module gate_driver_status_regs
    import gate_status_pkg::*;
(
    input wire logic mclk_in,
    input wire logic resetn_in,
    // Register port
    input wire logic [`ADDR_W-1:0] reg_addr_in,
    input wire logic [`STAT_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [`STAT_W-1:0] reg_rdata_out,
    // Comparator levels, 1 means above threshold
    input wire logic low_pump_undervolt_state_in,
    input wire logic high_pump_undervolt_state_in,
    input wire logic logic_rail_undervolt_state_in,
    input wire logic logic_rail_overvolt_state_in,
    input wire logic buck_rail_undervolt_state_in,
    input wire logic buck_rail_overvolt_state_in,
    // Motor supply converter
    input wire logic [`ADC_W-1:0] motor_supply_reading_in,
    input wire logic motor_supply_valid_in,
    // Hall pins and strap
    input wire logic [`HALL_W-1:0] hall_input_levels_in,
    input wire logic logic_rail_setpoint_in,
    // Active sense amplifier gain
    input wire logic [`GAIN_W-1:0] sense_amp_gain_code_in
);

    ////////////////////////////////////////////////////////////////////////
    // Input conditioning

    logic [`CMP_W-1:0] cmp_raw;
    logic [`CMP_W-1:0] cmp_sync;
    hall_levels_t hall_sync;
    logic setpoint_sync;
    logic setpoint_held;

    assign cmp_raw[`CMP_LOW_PUMP] = low_pump_undervolt_state_in;
    assign cmp_raw[`CMP_HIGH_PUMP] = high_pump_undervolt_state_in;
    assign cmp_raw[`CMP_LOGIC_UV] = logic_rail_undervolt_state_in;
    assign cmp_raw[`CMP_LOGIC_OV] = logic_rail_overvolt_state_in;
    assign cmp_raw[`CMP_BUCK_UV] = buck_rail_undervolt_state_in;
    assign cmp_raw[`CMP_BUCK_OV] = buck_rail_overvolt_state_in;

    sync_vec #(
        .WIDTH(`CMP_W)
    ) u_cmp_sync (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .async_in(cmp_raw),
        .sync_out(cmp_sync)
    );

    sync_vec #(
        .WIDTH(`HALL_W)
    ) u_hall_sync (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .async_in(hall_input_levels_in),
        .sync_out(hall_sync)
    );

    sync_vec #(
        .WIDTH(1)
    ) u_strap_sync (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .async_in(logic_rail_setpoint_in),
        .sync_out(setpoint_sync)
    );

    strap_latch u_strap (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .strap_in(setpoint_sync),
        .strap_out(setpoint_held)
    );

    ////////////////////////////////////////////////////////////////////////
    // Converter result and gain code

    adc_value_t motor_q;
    gain_code_t gain_q;

    // Keeps the latest completed conversion
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            motor_q <= `ADC_RESET;
        end else if (motor_supply_valid_in) begin
            motor_q <= motor_supply_reading_in;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            gain_q <= `GAIN_RESET;
        end else begin
            gain_q <= sense_amp_gain_code_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status words

    status_word_t supply_word;
    status_word_t func_word;

    always_comb begin
        supply_word = `STATUS_RESET;
        supply_word[`LOW_PUMP_UV_BIT] = cmp_sync[`CMP_LOW_PUMP];
        supply_word[`HIGH_PUMP_UV_BIT] = cmp_sync[`CMP_HIGH_PUMP];
        supply_word[`LOGIC_UV_BIT] = cmp_sync[`CMP_LOGIC_UV];
        supply_word[`LOGIC_OV_BIT] = cmp_sync[`CMP_LOGIC_OV];
        supply_word[`BUCK_UV_BIT] = cmp_sync[`CMP_BUCK_UV];
        supply_word[`BUCK_OV_BIT] = cmp_sync[`CMP_BUCK_OV];
        supply_word[`MOTOR_READ_MSB:`MOTOR_READ_LSB] = motor_q;
    end

    always_comb begin
        func_word = `STATUS_RESET;
        func_word[`HALL_MSB:`HALL_LSB] = hall_sync;
        // Same level on all three phases in the same sample
        func_word[`HALL_EQ_BIT] = (&hall_sync) | ~(|hall_sync);
        func_word[`SETPOINT_BIT] = setpoint_held;
        func_word[`GAIN_MSB:`GAIN_LSB] = gain_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register port

    logic read_take;
    status_word_t rdata_d;
    status_word_t rdata_q;

    // Writes decode to nothing; wdata is never stored
    assign read_take = reg_rd_in & ~reg_wr_in;

    always_comb begin
        rdata_d = `STATUS_RESET;
        if (read_take) begin
            case (reg_addr_in)
                `SUPPLY_STATUS_OFS: rdata_d = supply_word;
                `FUNC_STATUS_OFS: rdata_d = func_word;
                default: rdata_d = `STATUS_RESET;
            endcase
        end
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_q <= `STATUS_RESET;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_out = rdata_q;

endmodule // gate_driver_status_regs

// *** gate_status_props.sv ***
// Checker for the status register bank read port.
// Assumes it is bound into gate_driver_status_regs.
`timescale 1ns/1ps
`include "gate_status_cfg.svh"

module gate_status_props (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic [`ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [`STAT_W-1:0] reg_rdata_out,
    input wire logic [`ADC_W-1:0] motor_supply_reading_in,
    input wire logic motor_supply_valid_in,
    input wire logic [`HALL_W-1:0] hall_input_levels_in,
    input wire logic [`GAIN_W-1:0] sense_amp_gain_code_in
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_sup;
        reg_rd_in && !reg_wr_in && reg_addr_in == `SUPPLY_STATUS_OFS;
    endsequence
    sequence s_fun;
        reg_rd_in && !reg_wr_in && reg_addr_in == `FUNC_STATUS_OFS;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_idle_zero: assert property (
        !reg_rd_in |=> reg_rdata_out == 16'h0000)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (reg_rd_in && !reg_wr_in
        && reg_addr_in != `SUPPLY_STATUS_OFS
        && reg_addr_in != `FUNC_STATUS_OFS |=> reg_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    a_supply_top: assert property (
        s_sup |=> reg_rdata_out[15:13] == 3'h0)
        else $error("supply upper bits set");
    a_func_top: assert property (
        s_fun |=> reg_rdata_out[15:8] == 8'h00)
        else $error("functional upper bits set");
    a_hall_equal: assert property (s_fun |=> reg_rdata_out[3] ==
        ((&reg_rdata_out[2:0]) || !(|reg_rdata_out[2:0])))
        else $error("hall equal bit wrong");
    a_hall_tracks: assert property ((s_fun
        ##0 ($stable(hall_input_levels_in) && hall_input_levels_in
        == $past(hall_input_levels_in, 2)))
        |=> reg_rdata_out[2:0] == $past(hall_input_levels_in))
        else $error("hall levels wrong");
    a_gain_tracks: assert property ((s_fun
        ##0 $stable(sense_amp_gain_code_in))
        |=> reg_rdata_out[7:5] == $past(sense_amp_gain_code_in))
        else $error("gain code wrong");
    a_motor_value: assert property (
        (motor_supply_valid_in ##1 s_sup)
        |=> reg_rdata_out[12:6] == $past(motor_supply_reading_in, 2))
        else $error("motor reading wrong");
endmodule // gate_status_props

// *** host_model.sv ***
// Host model issuing reads and writes on the register port.
// Assumes the bank answers a read in the following cycle only.
`timescale 1ns/1ps
`include "gate_status_cfg.svh"

module host_model (
    input wire logic mclk_in,
    input wire logic [`STAT_W-1:0] reg_rdata_in,
    output logic [`ADDR_W-1:0] reg_addr_out,
    output logic [`STAT_W-1:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out
);
    initial begin
        {reg_addr_out, reg_wdata_out, reg_wr_out, reg_rd_out} = '0;
    end
    // Released lines show the inverse of the last value
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge mclk_in);
        reg_addr_out <= a;
        reg_wdata_out <= v;
        reg_wr_out <= 1'b1;
        @(posedge mclk_in);
        reg_wr_out <= 1'b0;
        reg_addr_out <= ~a;
        reg_wdata_out <= ~v;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge mclk_in);
        reg_addr_out <= a;
        reg_rd_out <= 1'b1;
        @(posedge mclk_in);
        reg_rd_out <= 1'b0;
        reg_addr_out <= ~a;
        #1 v = reg_rdata_in;
    endtask
endmodule // host_model

// *** tb_top.sv ***
// Self-checking bench for the status register bank.
// Assumes host_model and gate_status_props are compiled before it.
`timescale 1ns/1ps
`include "gate_status_cfg.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
    $display("Error %0t: got %h want %h", $time, a, b); end end

module tb_top
    import gate_status_pkg::*;
();
    logic mclk_in = 1'b0;
    logic resetn_in = 1'b0;
    reg_addr_t addr;
    status_word_t wd, rdata, d, d2;
    logic wr, rd, vld, sp;
    logic [5:0] cmp;
    adc_value_t mot, mot_e;
    hall_levels_t hall;
    gain_code_t gain;
    int mismatches = 0, checked = 0, cyc = 0, i;
    integer seed = 32'hc894;
    ////////////////////////////////////////////////////////////////////////
    function automatic status_word_t sup_exp(logic [5:0] c, adc_value_t m);
        return {3'h0, m, c};
    endfunction
    function automatic status_word_t fun_exp(hall_levels_t h, gain_code_t g,
        logic s);
        return {8'h00, g, s, (&h) | ~(|h), h};
    endfunction
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2.5 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            end_of_test();
        end
    end
    host_model host (.mclk_in(mclk_in), .reg_rdata_in(rdata),
        .reg_addr_out(addr), .reg_wdata_out(wd), .reg_wr_out(wr),
        .reg_rd_out(rd));
    gate_driver_status_regs dut (.mclk_in(mclk_in), .resetn_in(resetn_in),
        .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata),
        .low_pump_undervolt_state_in(cmp[0]),
        .high_pump_undervolt_state_in(cmp[1]),
        .logic_rail_undervolt_state_in(cmp[2]),
        .logic_rail_overvolt_state_in(cmp[3]),
        .buck_rail_undervolt_state_in(cmp[4]),
        .buck_rail_overvolt_state_in(cmp[5]),
        .motor_supply_reading_in(mot), .motor_supply_valid_in(vld),
        .hall_input_levels_in(hall), .logic_rail_setpoint_in(sp),
        .sense_amp_gain_code_in(gain));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {cmp, mot, mot_e, hall, gain, vld} = '0;
        sp = 1'b1;
        repeat (5) @(posedge mclk_in);
        resetn_in <= 1'b1;
        host.rd(`SUPPLY_STATUS_OFS, d);
        `CHK(d, `STATUS_RESET)
        repeat (8) @(posedge mclk_in);
        // Strap moves after capture and must be ignored
        sp <= 1'b0;
        $display("test reset done");
        for (i = 0; i < 40; i++) begin
            @(posedge mclk_in);
            cmp <= 6'($random(seed));
            hall <= i < 2 ? {3{i[0]}} : 3'($random(seed));
            gain <= i[2:0];
            mot <= 7'($random(seed));
            vld <= (i % 3 != 2);
            @(posedge mclk_in);
            if (vld) mot_e = mot;
            vld <= 1'b0;
            host.wr({7'h01, i[0]}, 16'($random(seed)));
            host.rd(`SUPPLY_STATUS_OFS, d);
            host.rd(`SUPPLY_STATUS_OFS, d2);
            `CHK(d[5:0], cmp)
            `CHK(d, sup_exp(cmp, mot_e))
            `CHK(d2, d)
            host.rd(`FUNC_STATUS_OFS, d);
            `CHK(d, fun_exp(hall, gain, 1'b1))
            `CHK(d[7:5], gain)
            host.rd({4'h1, i[3:0]}, d);
            `CHK(d, 16'h0000)
        end
        $display("test random done");
        // Read strobed in the cycle right after a conversion lands
        for (i = 0; i < 2; i++) begin
            @(posedge mclk_in);
            mot <= i[0] ? 7'h7f : 7'h2a;
            vld <= 1'b1;
            fork
                host.rd(`SUPPLY_STATUS_OFS, d);
                begin
                    @(posedge mclk_in);
                    vld <= 1'b0;
                end
            join
            mot_e = mot;
            `CHK(d, sup_exp(cmp, mot_e))
        end
        $display("test conversion done");
        // Mid-run reset: held reading clears, strap now captured low
        @(posedge mclk_in);
        resetn_in <= 1'b0;
        repeat (5) @(posedge mclk_in);
        resetn_in <= 1'b1;
        repeat (12) @(posedge mclk_in);
        mot_e = '0;
        host.rd(`SUPPLY_STATUS_OFS, d);
        `CHK(d, sup_exp(cmp, mot_e))
        host.rd(`FUNC_STATUS_OFS, d);
        `CHK(d, fun_exp(hall, gain, 1'b0))
        $display("test mid reset done");
        end_of_test();
    end
endmodule // tb_top

bind gate_driver_status_regs gate_status_props chk (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .motor_supply_reading_in(motor_supply_reading_in),
    .motor_supply_valid_in(motor_supply_valid_in),
    .hall_input_levels_in(hall_input_levels_in),
    .sense_amp_gain_code_in(sense_amp_gain_code_in)
);
